// File: hw/sct_ctl_end.sv
// Controller end: power-up sequence, periodic refresh, single-word
// accesses with auto precharge, power-down and self refresh on request.
// Assumes the user side is synchronous to clock.
`timescale 1ns/1ps
module sct_ctl_end #(
  parameter int DW = 16,
  parameter int CL = 2,
  parameter int FAST_GRADE = 0,
  parameter int INIT_CYC = sct_pkg::INIT_CYC,
  parameter int REFI_CYC = sct_pkg::REFI_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  sct_link_if.ctl link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_bank,
  input wire logic [11:0] req_row,
  input wire logic [7:0] req_col,
  input wire logic [DW-1:0] req_wdata,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DW-1:0] rd_data,
  input wire logic pd_req,
  input wire logic sr_req,
  output logic init_done
);
  import sct_pkg::*;

  initial
  begin
    if ((CL != 2 && CL != 3) || (FAST_GRADE != 0 && CL == 2) || INIT_CYC < 1 || REFI_CYC < 8)
      $error("sct_ctl_end: unsupported latency or timing");
  end

  localparam int DAL_CYC = (FAST_GRADE != 0) ? T_DAL_FAST_CK : T_DAL_CK;

  typedef enum {S_INIT, S_PREA, S_REF1, S_REF2, S_LMR, S_IDLE, S_ACT, S_COL, S_WAIT,
                S_PD, S_SR, S_SRX} sct_state_t;

  sct_state_t state_reg;
  sct_state_t ret_reg;
  logic [15:0] wait_reg;
  logic [15:0] refi_reg;
  logic ref_due_reg;
  logic ref_take;
  logic [2:0] cap_reg;
  logic [DW-1:0] buf_reg [2];
  logic wp_reg;
  logic rp_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;
  logic req_write_reg;
  logic [7:0] col_hold_reg;

  // Accept only when idle, no refresh, power-down or self refresh pending, and for reads when read space exists
  assign req_ready = (state_reg == S_IDLE) && !ref_due_reg && !pd_req && !sr_req &&
                     (req_write || cnt_reg < 2'h2);
  assign ref_take = (state_reg == S_IDLE) && ref_due_reg;

  // Periodic refresh request; a new tick wins over the clear
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      refi_reg <= 16'h0000;
      ref_due_reg <= 1'b0;
    end
    else if (refi_reg >= 16'(REFI_CYC - 1))
    begin
      refi_reg <= 16'h0000;
      ref_due_reg <= init_done;
    end
    else
    begin
      refi_reg <= refi_reg + 16'h0001;
      if (ref_take)
        ref_due_reg <= 1'b0;
    end
  end

  // Sequencer and pin drive
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      state_reg <= S_INIT;
      ret_reg <= S_INIT;
      wait_reg <= 16'(INIT_CYC);
      init_done <= 1'b0;
      link.cke <= 1'b1;
      link.cs_n <= 1'b1;
      {link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
      link.ba <= 2'h0;
      link.addr <= 12'h000;
      link.dqm <= 1'b1;
      link.dq_ctl <= '0;
      link.oe_ctl <= 1'b0;
      cap_reg <= 3'h0;
      req_write_reg <= 1'b0;
    end
    else
    begin
      link.cs_n <= 1'b0;
      {link.ras_n, link.cas_n, link.we_n} <= CMD_NOP;
      link.oe_ctl <= 1'b0;
      link.dqm <= 1'b0;
      cap_reg <= (cap_reg != 3'h0) ? cap_reg - 3'h1 : 3'h0;
      unique case (state_reg)
        S_INIT, S_WAIT:
        begin
          if (wait_reg <= 16'h0001)
            state_reg <= (state_reg == S_INIT) ? S_PREA : ret_reg;
          else
            wait_reg <= wait_reg - 16'h0001;
        end
        S_PREA:
        begin
          {link.ras_n, link.cas_n, link.we_n} <= CMD_PRE;
          link.addr <= 12'(1 << AP_BIT);
          wait_reg <= 16'(RP_CYC + 1);
          ret_reg <= S_REF1;
          state_reg <= S_WAIT;
        end
        S_REF1, S_REF2:
        begin
          {link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
          wait_reg <= 16'(RFC_CYC + 1);
          ret_reg <= (state_reg == S_REF1) ? S_REF2 : S_LMR;
          state_reg <= S_WAIT;
        end
        S_LMR:
        begin
          {link.ras_n, link.cas_n, link.we_n} <= CMD_LMR;
          link.addr <= 12'(CL << MR_CL_LSB);
          link.ba <= 2'h0;
          wait_reg <= 16'(T_MRD_STD_CK + 1);
          ret_reg <= S_IDLE;
          state_reg <= S_WAIT;
          init_done <= 1'b1;
        end
        S_IDLE:
        begin
          if (ref_take)
          begin
            {link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
            wait_reg <= 16'(RFC_CYC + 1);
            ret_reg <= S_IDLE;
            state_reg <= S_WAIT;
          end
          else if (sr_req)
          begin
            {link.ras_n, link.cas_n, link.we_n} <= CMD_REF;
            link.cke <= 1'b0;
            state_reg <= S_SR;
          end
          else if (pd_req)
          begin
            link.cke <= 1'b0;
            state_reg <= S_PD;
          end
          else if (req_valid && req_ready)
          begin
            {link.ras_n, link.cas_n, link.we_n} <= CMD_ACT;
            link.ba <= req_bank;
            link.addr <= req_row;
            req_write_reg <= req_write;
            link.dq_ctl <= req_wdata;
            state_reg <= (RCD_CYC > 1) ? S_ACT : S_COL;
            wait_reg <= 16'(RCD_CYC - 1);
          end
        end
        S_ACT:
        begin
          if (wait_reg <= 16'h0001)
            state_reg <= S_COL;
          else
            wait_reg <= wait_reg - 16'h0001;
        end
        S_COL:
        begin
          // Auto precharge bit set, column from the held request
          link.addr <= {4'h4, col_hold_reg};
          {link.ras_n, link.cas_n, link.we_n} <= req_write_reg ? CMD_WR : CMD_RD;
          link.oe_ctl <= req_write_reg;
          if (!req_write_reg)
            cap_reg <= 3'(CL + 1);
          wait_reg <= req_write_reg ? 16'(DAL_CYC + 1) : 16'(CL + RP_CYC + 1);
          ret_reg <= S_IDLE;
          state_reg <= S_WAIT;
        end
        S_PD:
        begin
          if (!pd_req)
          begin
            link.cke <= 1'b1;
            wait_reg <= 16'h0002;
            ret_reg <= S_IDLE;
            state_reg <= S_WAIT;
          end
          else
            link.cs_n <= 1'b1;
        end
        S_SR:
        begin
          link.cs_n <= 1'b1;
          if (!sr_req)
          begin
            link.cke <= 1'b1;
            state_reg <= S_SRX;
          end
        end
        S_SRX:
        begin
          wait_reg <= 16'(XSR_CYC + 1);
          ret_reg <= S_IDLE;
          state_reg <= S_WAIT;
        end
      endcase
    end
  end

  // Column held from the accepted request
  always_ff @(posedge clock)
  begin
    if (!resetn)
      col_hold_reg <= 8'h00;
    else if (state_reg == S_IDLE && req_valid && req_ready)
      col_hold_reg <= req_col;
  end

  // Two-entry read buffer; reads are issued only while a slot is free
  assign push = (cap_reg == 3'h1);
  assign pop = rd_valid && rd_ready;
  assign rd_valid = (cnt_reg != 2'h0);
  assign rd_data = buf_reg[rp_reg];

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wp_reg <= 1'b0;
      rp_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (push)
        wp_reg <= !wp_reg;
      if (pop)
        rp_reg <= !rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      buf_reg[wp_reg] <= link.dq;
  end

endmodule // sct_ctl_end

// File: hw/sct_pkg.sv
// Shared constants for the DRAM command link: command codes, mode fields,
// timing figures and their cycle counts.
// Assumes a single 50 MHz clock shared by both ends of the link.
package sct_pkg;

  // Clock
  localparam int CLK_PERIOD_PS = 20000;

  // Least time in ps to whole cycles, never below one
  function automatic int min_cyc(input int ps);
    int c;
    c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Times as printed, then cycle counts
  localparam int T_INIT_US = 100;
  localparam int INIT_CYC = T_INIT_US * 1000000 / CLK_PERIOD_PS;
  localparam int T_REFI_PS = 15625000;
  localparam int REFI_CYC = T_REFI_PS / CLK_PERIOD_PS;
  localparam int T_RCD_PS = 20000;
  localparam int RCD_CYC = min_cyc(T_RCD_PS);
  localparam int T_RP_PS = 20000;
  localparam int RP_CYC = min_cyc(T_RP_PS);
  localparam int T_RFC_PS = 66000;
  localparam int RFC_CYC = min_cyc(T_RFC_PS);
  localparam int T_XSR_PS = 75000;
  localparam int XSR_MIN_CK = 2;
  localparam int XSR_CYC = (min_cyc(T_XSR_PS) < XSR_MIN_CK) ? XSR_MIN_CK : min_cyc(T_XSR_PS);
  localparam int T_WR_MAN_PS = 15000;
  localparam int WR_MAN_CYC = min_cyc(T_WR_MAN_PS);
  localparam int T_APD_PS = 7500;
  localparam int T_APD_FAST_PS = 6000;

  // Clock-count figures
  localparam int T_CCD_CK = 1;
  localparam int T_DQZ_CK = 2;
  localparam int T_DAL_CK = 5;
  localparam int T_DAL_FAST_CK = 4;
  localparam int T_DPL_CK = 2;
  localparam int T_MRD_CK = 2;
  localparam int T_MRD_STD_CK = 3;
  localparam int T_ROH2_FAST_CK = 1;

  // Command code {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR  = 3'h4,
    CMD_RD  = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sct_cmd_t;

  // Mode register layout and address fields
  localparam int MR_BL_LSB = 0;
  localparam int MR_CL_LSB = 4;
  localparam int AP_BIT = 10;
  localparam logic [11:0] MR_RESET = 12'h0030;
  localparam logic [11:0] COL_MASK_X4 = 12'h03FF;
  localparam logic [11:0] COL_MASK_X8 = 12'h01FF;
  localparam logic [11:0] COL_MASK_X16 = 12'h00FF;

endpackage

// File: hw/sct_link_if.sv
// Pin-level link between the memory controller end and the DRAM end.
// The shared data bus is resolved here from the two output enables.
`timescale 1ns/1ps
interface sct_link_if #(parameter int DW = 16) (input logic clock);
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] ba;
  logic [11:0] addr;
  logic dqm;
  logic [DW-1:0] dq_ctl;
  logic oe_ctl;
  logic [DW-1:0] dq_mem;
  logic oe_mem;
  logic [DW-1:0] dq;

  // Bus level: the driving end wins, idle bus reads as zero
  assign dq = oe_mem ? dq_mem : (oe_ctl ? dq_ctl : '0);

  modport ctl (input clock, output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
               output dq_ctl, oe_ctl, input dq);
  modport mem (input clock, input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
               output dq_mem, oe_mem, input dq);
endinterface

// File: hw/sct_mem_end.sv
// DRAM device end: command decode, clock suspend, bursts, masks, refresh.
// Assumes link inputs are synchronous to clock and a small storage array.
`timescale 1ns/1ps
// Function
// - Column commands may come every clock.
// - Suspend one clock after CKE low.
// - Resume one clock after CKE high.
// - Write mask acts on same-clock data.
// - Read mask floats outputs two clocks later.
// - First write word captured with command.
// - Wait DAL clocks before reactivating bank.
// - Two clocks from last data to precharge.
// - Burst stop one clock after last data.
// - New column command one clock later.
// - Mode load to activate needs spacing.
// - Precharge floats read outputs after ROH.
// - Init pause then two refreshes.
// - Clock steady during accesses; CKE throttles.
// - Two clocks after self refresh exit.
// - Auto-precharge starts fixed delay after write.
// - No CAS latency two on fastest grade.
// - Chip select high means no operation.
// - One refresh cycle per refresh command.
// - Self refresh has no time limit.
// - 15ns from write data to precharge.
// - Width-dependent column bits are ignored.
module sct_mem_end #(
  parameter int WIDTH_X = 16,
  parameter int FAST_GRADE = 0,
  parameter int MEM_AW = 8,
  parameter int REFI_CYC = sct_pkg::REFI_CYC
) (
  input wire logic clock,
  input wire logic resetn,
  sct_link_if.mem link,
  output logic [15:0] refresh_count,
  output logic self_refresh,
  output logic suspended,
  output logic [3:0] banks_open
);
  import sct_pkg::*;

  localparam int APD_CYC = 1 + min_cyc(FAST_GRADE != 0 ? T_APD_FAST_PS : T_APD_PS);
  localparam logic [11:0] COL_MASK = (WIDTH_X == 4) ? COL_MASK_X4 :
                                     (WIDTH_X == 8) ? COL_MASK_X8 : COL_MASK_X16;

  initial
  begin
    if (!(WIDTH_X == 4 || WIDTH_X == 8 || WIDTH_X == 16) || MEM_AW < 3 || MEM_AW > 10)
      $error("sct_mem_end: unsupported width or array size");
  end

  logic cke_q_reg;
  logic live;
  sct_cmd_t cmd;
  logic [11:0] mode_reg;
  logic [2:0] cl;
  logic [3:0] bl;
  logic [11:0] col;
  logic [3:0] wr_cnt_reg;
  logic [MEM_AW-3:0] wr_col_reg;
  logic [1:0] wr_ba_reg;
  logic wr_ap_reg;
  logic [3:0] rd_cnt_reg;
  logic [MEM_AW-3:0] rd_col_reg;
  logic [1:0] rd_ba_reg;
  logic rd_ap_reg;
  logic [2:0] ap_cnt_reg;
  logic [1:0] ap_ba_reg;
  logic mem_we;
  logic [MEM_AW-1:0] mem_widx;
  logic gen_v;
  logic [MEM_AW-1:0] gen_idx;
  logic [2:0] pipe_v_reg;
  logic [WIDTH_X-1:0] pipe_d_reg [3];
  logic [1:0] dqm_d_reg;
  logic [WIDTH_X-1:0] mem [2**MEM_AW];
  logic [15:0] sr_tmr_reg;
  logic pre_hit_rd;

  // Edge-sampled CKE: the following edge is frozen or resumed
  always_ff @(posedge clock)
  begin
    if (!resetn)
      cke_q_reg <= 1'b0;
    else
      cke_q_reg <= link.cke;
  end
  assign live = cke_q_reg && !self_refresh;
  assign suspended = !cke_q_reg;

  // Command decode; a deselected cycle is a no-operation
  assign cmd = link.cs_n ? CMD_NOP : sct_cmd_t'({link.ras_n, link.cas_n, link.we_n});
  assign cl = mode_reg[MR_CL_LSB +: 3];
  assign bl = (mode_reg[MR_BL_LSB +: 3] > 3'h3) ? 4'h8 : 4'(1 << mode_reg[MR_BL_LSB +: 3]);
  assign col = link.addr & COL_MASK;
  assign pre_hit_rd = (cmd == CMD_PRE) && (link.addr[AP_BIT] || link.ba == rd_ba_reg);

  // Mode register load
  always_ff @(posedge clock)
  begin
    if (!resetn)
      mode_reg <= MR_RESET;
    else if (live && cmd == CMD_LMR)
      mode_reg <= link.addr;
  end

  // Write burst: first word with the command, mask checked per clock
  always_comb
  begin
    mem_we = 1'b0;
    mem_widx = {wr_ba_reg, wr_col_reg};
    if (live && cmd == CMD_WR)
    begin
      mem_we = !link.dqm;
      mem_widx = {link.ba, col[MEM_AW-3:0]};
    end
    else if (live && wr_cnt_reg != 4'h0 && cmd != CMD_BST && cmd != CMD_PRE && cmd != CMD_RD)
      mem_we = !link.dqm;
  end

  always_ff @(posedge clock)
  begin
    if (mem_we)
      mem[mem_widx] <= link.dq;
  end

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      wr_cnt_reg <= 4'h0;
      wr_col_reg <= '0;
      wr_ba_reg <= 2'h0;
      wr_ap_reg <= 1'b0;
    end
    else if (live && cmd == CMD_WR)
    begin
      wr_cnt_reg <= bl - 4'h1;
      wr_col_reg <= col[MEM_AW-3:0] + 1'b1;
      wr_ba_reg <= link.ba;
      wr_ap_reg <= link.addr[AP_BIT];
    end
    else if (live && (cmd == CMD_BST || cmd == CMD_PRE || cmd == CMD_RD))
      wr_cnt_reg <= 4'h0;
    else if (live && wr_cnt_reg != 4'h0)
    begin
      wr_cnt_reg <= wr_cnt_reg - 4'h1;
      wr_col_reg <= wr_col_reg + 1'b1;
    end
  end

  // Read burst generation; a precharge of its bank or of all banks, a write or burst stop ends it
  assign gen_v = live && (cmd == CMD_RD || (rd_cnt_reg != 4'h0 && cmd != CMD_BST &&
                 !pre_hit_rd && cmd != CMD_WR));
  assign gen_idx = (cmd == CMD_RD) ? {link.ba, col[MEM_AW-3:0]} : {rd_ba_reg, rd_col_reg};

  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      rd_cnt_reg <= 4'h0;
      rd_col_reg <= '0;
      rd_ba_reg <= 2'h0;
      rd_ap_reg <= 1'b0;
    end
    else if (live && cmd == CMD_RD)
    begin
      rd_cnt_reg <= bl - 4'h1;
      rd_col_reg <= col[MEM_AW-3:0] + 1'b1;
      rd_ba_reg <= link.ba;
      rd_ap_reg <= link.addr[AP_BIT];
    end
    else if (live && (cmd == CMD_BST || cmd == CMD_WR || pre_hit_rd))
      rd_cnt_reg <= 4'h0;
    else if (live && rd_cnt_reg != 4'h0)
    begin
      rd_cnt_reg <= rd_cnt_reg - 4'h1;
      rd_col_reg <= rd_col_reg + 1'b1;
    end
  end

  // Latency pipeline and read mask delay, frozen while suspended
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      pipe_v_reg <= 3'h0;
      dqm_d_reg <= 2'h0;
    end
    else if (cke_q_reg)
    begin
      if (live && pre_hit_rd && FAST_GRADE != 0 && cl == 3'h2)
        pipe_v_reg <= {2'h0, 1'b0};
      else
        pipe_v_reg <= {pipe_v_reg[1:0], gen_v};
      dqm_d_reg <= {dqm_d_reg[0], link.dqm};
    end
  end

  always_ff @(posedge clock)
  begin
    if (cke_q_reg)
    begin
      pipe_d_reg[0] <= mem[gen_idx];
      pipe_d_reg[1] <= pipe_d_reg[0];
      pipe_d_reg[2] <= pipe_d_reg[1];
    end
  end

  // Output tap at the programmed latency; mask floats it two clocks on
  assign link.dq_mem = pipe_d_reg[(cl == 3'h2) ? 1 : 2];
  assign link.oe_mem = pipe_v_reg[(cl == 3'h2) ? 1 : 2] && !dqm_d_reg[T_DQZ_CK-1];

  // Auto-precharge timer starts on the clock of the last written word
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ap_cnt_reg <= 3'h0;
      ap_ba_reg <= 2'h0;
    end
    else if (live && ((cmd == CMD_WR && bl == 4'h1 && link.addr[AP_BIT]) ||
             (wr_ap_reg && wr_cnt_reg == 4'h1)))
    begin
      ap_cnt_reg <= 3'(APD_CYC);
      ap_ba_reg <= (cmd == CMD_WR) ? link.ba : wr_ba_reg;
    end
    else if (ap_cnt_reg != 3'h0)
      ap_cnt_reg <= ap_cnt_reg - 3'h1;
  end

  // Bank row state
  always_ff @(posedge clock)
  begin
    if (!resetn)
      banks_open <= 4'h0;
    else if (live)
    begin
      if (cmd == CMD_ACT)
        banks_open[link.ba] <= 1'b1;
      else if (cmd == CMD_PRE && link.addr[AP_BIT])
        banks_open <= 4'h0;
      else if (cmd == CMD_PRE)
        banks_open[link.ba] <= 1'b0;
      else if (ap_cnt_reg == 3'h1)
        banks_open[ap_ba_reg] <= 1'b0;
      else if (rd_ap_reg && rd_cnt_reg == 4'h1)
        banks_open[rd_ba_reg] <= 1'b0;
      else if (cmd == CMD_RD && bl == 4'h1 && link.addr[AP_BIT])
        banks_open[link.ba] <= 1'b0; // Single-word read closes at once
    end
  end

  // Refresh: one cycle per command; self refresh runs until CKE returns
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      refresh_count <= 16'h0000;
      self_refresh <= 1'b0;
      sr_tmr_reg <= 16'h0000;
    end
    else if (self_refresh)
    begin
      if (link.cke)
        self_refresh <= 1'b0;
      if (sr_tmr_reg >= 16'(REFI_CYC - 1))
      begin
        sr_tmr_reg <= 16'h0000;
        refresh_count <= refresh_count + 16'h0001;
      end
      else
        sr_tmr_reg <= sr_tmr_reg + 16'h0001;
    end
    else if (live && cmd == CMD_REF)
    begin
      refresh_count <= refresh_count + 16'h0001;
      self_refresh <= !link.cke;
      sr_tmr_reg <= 16'h0000;
    end
  end

endmodule // sct_mem_end

// File: testbench/sct_link_asserts.sv
// Checker of command spacing and data timing on the link.
// Placed beside the link interface by the bench; sees its signals only.
`timescale 1ns/1ps
module sct_link_asserts
  import sct_pkg::*;
(
  input logic clock,
  input logic resetn,
  input logic cs_n,
  input logic ras_n,
  input logic cas_n,
  input logic we_n,
  input logic [11:0] addr,
  input logic dqm,
  input logic oe_ctl,
  input logic oe_mem
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Command decode
  sct_cmd_t cmd;
  logic wr, rd, act, pre, lmr, refr;
  logic [1:0] ref_cnt_reg;
  assign cmd = sct_cmd_t'({ras_n, cas_n, we_n});
  assign wr = !cs_n && cmd == CMD_WR;
  assign rd = !cs_n && cmd == CMD_RD;
  assign act = !cs_n && cmd == CMD_ACT;
  assign pre = !cs_n && cmd == CMD_PRE;
  assign lmr = !cs_n && cmd == CMD_LMR;
  assign refr = !cs_n && cmd == CMD_REF;
  // Refreshes seen since reset, saturating
  always_ff @(posedge clock)
  begin
    if (!resetn)
      ref_cnt_reg <= 2'h0;
    else if (refr && ref_cnt_reg != 2'h3)
      ref_cnt_reg <= ref_cnt_reg + 2'h1;
  end
  AST_WR_DATA: assert property (wr |-> oe_ctl)
    else $error("write word not driven with write command");
  AST_DAL: assert property (wr |-> addr[AP_BIT] ##1 !act [*5])
    else $error("activate too soon after write");
  AST_DPL: assert property (wr |=> !pre [*2])
    else $error("precharge too soon after write");
  AST_MRD: assert property (lmr |=> (!act && !refr) [*3])
    else $error("command too soon after mode load");
  AST_INIT: assert property (lmr |-> ref_cnt_reg >= 2'h2)
    else $error("mode load before two refreshes");
  AST_RD_LAT: assert property (rd && !dqm |-> ##2 oe_mem)
    else $error("read word missing");
  AST_DQZ: assert property (dqm |-> ##2 !oe_mem)
    else $error("masked read still driven");
  AST_OE_CAUSE: assert property (oe_mem |-> $past(rd, 2))
    else $error("output driven without read");
  AST_ONE_WORD: assert property (oe_mem |=> !oe_mem)
    else $error("output not released after word");
endmodule // sct_link_asserts

// File: testbench/sdram_command_timing_tb.sv
// Bench for the DRAM link: controller end facing device end.
// Assumes one 50 MHz clock; init and refresh counts shortened.
`timescale 1ns/1ps
module sdram_command_timing_tb;
  import sct_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [1:0] req_bank = 2'h0;
  logic [11:0] req_row = 12'h000;
  logic [7:0] req_col = 8'h00;
  logic [15:0] req_wdata = 16'h0000;
  logic rd_ready = 1'b0;
  logic pd_req = 1'b0;
  logic sr_req = 1'b0;
  logic req_ready, rd_valid, init_done, self_refresh, suspended;
  logic [15:0] rd_data, refresh_count, r0;
  logic [3:0] banks_open;
  logic [15:0] exp_mem [0:255];
  logic [7:0] keys [0:9];
  integer seed = 32'h13b663ae;
  int fails = 0;
  int compares = 0;

  // Clock at 50 MHz
  always #10 clock = ~clock;

  sct_link_if u_sct_link_if (.clock(clock));
  sct_ctl_end #(.CL(2), .INIT_CYC(20), .REFI_CYC(40)) u_sct_ctl_end (
    .clock(clock), .resetn(resetn), .link(u_sct_link_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_bank(req_bank), .req_row(req_row), .req_col(req_col),
    .req_wdata(req_wdata), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .pd_req(pd_req), .sr_req(sr_req), .init_done(init_done));
  sct_mem_end #(.REFI_CYC(40)) u_sct_mem_end (
    .clock(clock), .resetn(resetn), .link(u_sct_link_if),
    .refresh_count(refresh_count), .self_refresh(self_refresh),
    .suspended(suspended), .banks_open(banks_open));
  sct_link_asserts u_sct_link_asserts (
    .clock(clock), .resetn(resetn), .cs_n(u_sct_link_if.cs_n),
    .ras_n(u_sct_link_if.ras_n), .cas_n(u_sct_link_if.cas_n),
    .we_n(u_sct_link_if.we_n), .addr(u_sct_link_if.addr), .dqm(u_sct_link_if.dqm),
    .oe_ctl(u_sct_link_if.oe_ctl), .oe_mem(u_sct_link_if.oe_mem));

  // Verdict and end of run
  task automatic stop_test();
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bound on every wait
  task automatic guard(inout int n);
    n++;
    if (n > 400)
    begin
      fails++;
      stop_test();
    end
  endtask

  // Wait cycles, then step past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Raise a request for key {bank, col}
  task automatic start_req(input logic wr, input logic [7:0] k, input logic [15:0] d);
    tick(1);
    req_valid = 1'b1;
    req_write = wr;
    req_bank = k[7:6];
    req_col = {2'h0, k[5:0]};
    req_row = 12'($random(seed));
    req_wdata = d;
    if (wr)
      exp_mem[k] = d;
  endtask

  // Hold the request until taken
  task automatic take();
    int n;
    n = 0;
    @(negedge clock);
    while (req_ready !== 1'b1)
    begin
      guard(n);
      @(negedge clock);
    end
    tick(1);
    req_valid = 1'b0;
  endtask

  // Accept one read word and compare
  task automatic pop(input logic [7:0] k);
    int n;
    n = 0;
    tick(1);
    rd_ready = 1'b1;
    @(negedge clock);
    while (rd_valid !== 1'b1)
    begin
      guard(n);
      @(negedge clock);
    end
    chk("rd_data", rd_data, exp_mem[k]);
    tick(1);
    rd_ready = 1'b0;
  endtask

  // Wait for power-up sequence
  task automatic wait_init();
    int n;
    n = 0;
    while (init_done !== 1'b1)
    begin
      guard(n);
      tick(1);
    end
  endtask

  // Main sequence
  initial
  begin
    tick(3);
    chk("init_done", init_done, 16'h0000);
    resetn = 1'b1;
    wait_init();
    chk("init refreshes", refresh_count, 16'h0002);
    // Random writes back to back, corner keys first
    for (int i = 0; i < 10; i++)
    begin
      keys[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      start_req(1'b1, keys[i], (i == 1) ? 16'hffff : 16'($random(seed)));
      take();
    end
    for (int i = 0; i < 10; i++)
    begin
      start_req(1'b0, keys[i], 16'h0000);
      take();
      pop(keys[i]);
    end
    // Reader stalls: two words buffered, third refused
    start_req(1'b0, keys[2], 16'h0000);
    take();
    start_req(1'b0, keys[3], 16'h0000);
    take();
    start_req(1'b0, keys[4], 16'h0000);
    tick(30);
    chk("req_ready full", req_ready, 16'h0000);
    pop(keys[2]);
    take();
    pop(keys[3]);
    pop(keys[4]);
    // Idle refresh
    r0 = refresh_count;
    tick(100);
    chk("idle refresh", 16'(refresh_count - r0 >= 16'(100 / 40)), 16'h0001);
    chk("banks_open", banks_open, 16'h0000);
    // Power-down entry and exit
    pd_req = 1'b1;
    tick(20);
    chk("suspended", suspended, 16'h0001);
    chk("cke", u_sct_link_if.cke, 16'h0000);
    pd_req = 1'b0;
    tick(10);
    chk("suspended", suspended, 16'h0000);
    start_req(1'b0, keys[5], 16'h0000);
    take();
    pop(keys[5]);
    // Self refresh held long
    sr_req = 1'b1;
    tick(20);
    chk("self_refresh", self_refresh, 16'h0001);
    r0 = refresh_count;
    tick(200);
    chk("self_refresh", self_refresh, 16'h0001);
    chk("sr refresh", 16'(refresh_count - r0 >= 16'(200 / 40 - 1)), 16'h0001);
    sr_req = 1'b0;
    tick(20);
    chk("self_refresh", self_refresh, 16'h0000);
    start_req(1'b0, keys[1], 16'h0000);
    take();
    pop(keys[1]);
    stop_test();
  end
endmodule // sdram_command_timing_tb
